// [core/cfr_regbank.sv]
// Register bank of the CAN FD protocol controller, window 0x1000..0x10ff.
// Assumes host accesses arrive from the serial command decoder on MCLK_IN,
// and status words come from the protocol engine on the same clock.
//
// Summary of operation
// - Decode registers only inside window 0x1000..0x10ff
// - Message RAM start addresses are word aligned
// - Writes drop the two lowest start address bits
// - Data bit timing resets 0x00000a33, protected
// - Nominal bit timing resets 0x06000a03, protected
// - Delay compensation resets zero, protected
// - Extended id mask resets 0x1fffffff, protected
// - Rx fifo 0 acknowledge read/write, reset zero
// - Tx event fifo acknowledge read/write, reset zero
// - Cancel interrupt enables read/write, reset zero
// - Tx request pending read only, reset zero
`timescale 1ns/1ps
module cfr_regbank #(
    parameter logic [31:0] CORE_RELEASE = 32'h0000_0000 // Arbitrary value
) (
    input  wire logic                 MCLK_IN,
    input  wire logic                 NRST_IN,
    input  wire cfr_pkg::cfr_req_t    HOST_REQ_IN,
    input  wire cfr_pkg::cfr_stat_t   CORE_STAT_IN,
    input  wire logic [31:0]          IRQ_EVENT_IN,
    output logic      [31:0]          RDATA_OUT,
    output logic                      RVALID_OUT,
    output cfr_pkg::cfr_words_t       CFG_OUT,
    output logic                      TSVL_CLR_OUT,
    output logic                      TOVL_CLR_OUT,
    output logic                      RSVD_HIT_OUT,
    output logic                      PROT_BLOCK_OUT
);
    import cfr_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [15:0] word_addr;
    logic [5:0]  word_idx;
    logic [2:0]  acc_kind;
    logic        in_win;
    logic        wr_hit;
    logic        rd_hit;
    logic        prot_ok;
    logic [NUM_WORDS-1:0] we_vec;
    logic [31:0] word_w [NUM_WORDS];

    logic [31:0] cctl_q;
    logic [31:0] cctl_d;
    logic [31:0] iflg_q;
    logic [31:0] iflg_d;

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic        tsvl_clr_q;
    logic        tsvl_clr_d;
    logic        tovl_clr_q;
    logic        tovl_clr_d;
    logic        rsvd_hit_q;
    logic        rsvd_hit_d;
    logic        prot_blk_q;
    logic        prot_blk_d;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Byte lanes ignored: every access is a whole aligned word
    always_comb begin
        word_addr = {HOST_REQ_IN.addr[15:2], 2'b00};
        word_idx  = HOST_REQ_IN.addr[7:2];
        in_win    = (word_addr >= WIN_LO) && (word_addr <= WIN_HI);
        acc_kind  = in_win ? kind_of(word_addr) : K_RSVD;
        wr_hit    = HOST_REQ_IN.wr && in_win;
        rd_hit    = HOST_REQ_IN.rd && in_win;
    end

    // Protection is judged on the control word as it stands before the write
    assign prot_ok = cctl_q[CCTL_INIT] & cctl_q[CCTL_CHG];

    // Per-word write enables for the stored registers
    always_comb begin
        we_vec = '0;
        if (wr_hit) begin
            if (acc_kind == K_RW) begin
                we_vec[word_idx] = 1'b1;
            end else if (acc_kind == K_RP && prot_ok) begin
                we_vec[word_idx] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Stored words
    // ****************************************************************
    // One instance per read/write or protected word; masks drop start address low bits
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
            localparam logic [15:0] WOFS = 16'(WIN_LO + 16'(gi * 4));
            localparam logic [2:0]  WK   = kind_of(WOFS);
            if (WK == K_RW || WK == K_RP) begin : g_st
                cfr_reg #(
                    .RESET (reset_of(WOFS)),
                    .WMASK (wmask_of(WOFS))
                ) u_reg (
                    .clk_in   (MCLK_IN),
                    .rst_n_in (NRST_IN),
                    .wr_en_in (we_vec[gi]),
                    .wdata_in (HOST_REQ_IN.wdata),
                    .q_out    (word_w[gi])
                );
            end else if (WK == K_CTRL) begin : g_ctl
                assign word_w[gi] = cctl_q;
            end else if (WK == K_FLAG) begin : g_flg
                assign word_w[gi] = iflg_q;
            end else begin : g_none
                // Reserved and externally held words store nothing
                assign word_w[gi] = RST_ZERO;
            end
            assign CFG_OUT[gi] = word_w[gi];
        end
    endgenerate

    // ****************************************************************
    // Core control word
    // ****************************************************************
    // Init bit always writable; other low bits only while in init;
    // upper configuration bits need the full protection pair
    always_comb begin
        cctl_d = cctl_q;
        if (wr_hit && acc_kind == K_CTRL) begin
            cctl_d = (cctl_q & ~MSK_CCTL_A) | (HOST_REQ_IN.wdata & MSK_CCTL_A);
            if (cctl_q[CCTL_INIT]) begin
                cctl_d = (cctl_d & ~MSK_CCTL_I)
                       | (HOST_REQ_IN.wdata & MSK_CCTL_I);
            end
            if (prot_ok) begin
                cctl_d = (cctl_d & ~MSK_CCTL_P)
                       | (HOST_REQ_IN.wdata & MSK_CCTL_P);
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cctl_q <= RST_CCTL;
        end else begin
            cctl_q <= cctl_d;
        end
    end

    // ****************************************************************
    // Interrupt flags
    // ****************************************************************
    // Write one clears; an event in the clearing cycle still sets the bit
    always_comb begin
        iflg_d = iflg_q;
        if (wr_hit && acc_kind == K_FLAG) begin
            iflg_d = iflg_q & ~HOST_REQ_IN.wdata;
        end
        iflg_d = iflg_d | IRQ_EVENT_IN;
    end

    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            iflg_q <= RST_ZERO;
        end else begin
            iflg_q <= iflg_d;
        end
    end

    // ****************************************************************
    // Side effects of writes
    // ****************************************************************
    // Counter clears, reserved hits and blocked writes as one-cycle pulses
    always_comb begin
        tsvl_clr_d = wr_hit && (word_addr == OFS_TSVL);
        tovl_clr_d = wr_hit && (word_addr == OFS_TOVL);
        rsvd_hit_d = (HOST_REQ_IN.wr || HOST_REQ_IN.rd)
                     && (acc_kind == K_RSVD);
        prot_blk_d = wr_hit && (acc_kind == K_RP) && !prot_ok;
    end

    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tsvl_clr_q <= 1'b0;
            tovl_clr_q <= 1'b0;
            rsvd_hit_q <= 1'b0;
            prot_blk_q <= 1'b0;
        end else begin
            tsvl_clr_q <= tsvl_clr_d;
            tovl_clr_q <= tovl_clr_d;
            rsvd_hit_q <= rsvd_hit_d;
            prot_blk_q <= prot_blk_d;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Registered answer one cycle after the request; outside reads give 0
    always_comb begin
        rvalid_d = HOST_REQ_IN.rd;
        rdata_d  = RST_ZERO;
        if (rd_hit) begin
            case (word_addr)
                OFS_CREV:   rdata_d = CORE_RELEASE;
                OFS_ENDT:   rdata_d = RST_ENDT;
                OFS_CUSW:   rdata_d = RST_ZERO;
                OFS_TSVL:   rdata_d = CORE_STAT_IN.tsvl;
                OFS_TOVL:   rdata_d = CORE_STAT_IN.tovl;
                OFS_ECNT:   rdata_d = CORE_STAT_IN.ecnt;
                OFS_PSTAT:  rdata_d = CORE_STAT_IN.pstat;
                OFS_HPRI:   rdata_d = CORE_STAT_IN.hpri;
                OFS_RF0ST:  rdata_d = CORE_STAT_IN.rf0st;
                OFS_RF1ST:  rdata_d = CORE_STAT_IN.rf1st;
                OFS_TFQST:  rdata_d = CORE_STAT_IN.tfqst;
                OFS_TRPEND: rdata_d = CORE_STAT_IN.trpend;
                OFS_TXOCC:  rdata_d = CORE_STAT_IN.txocc;
                OFS_TCFIN:  rdata_d = CORE_STAT_IN.tcfin;
                OFS_TEFST:  rdata_d = CORE_STAT_IN.tefst;
                default:    rdata_d = word_w[word_idx];
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rdata_q  <= RST_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign RDATA_OUT      = rdata_q;
    assign RVALID_OUT     = rvalid_q;
    assign TSVL_CLR_OUT   = tsvl_clr_q;
    assign TOVL_CLR_OUT   = tovl_clr_q;
    assign RSVD_HIT_OUT   = rsvd_hit_q;
    assign PROT_BLOCK_OUT = prot_blk_q;
endmodule

// [common/cfr_pkg.sv]
// Constants, field layouts and carrier types of the CAN FD register bank.
// Assumes a 16-bit register address from the serial command decoder.
package cfr_pkg;

    // ****************************************************************
    // Window and word geometry
    // ****************************************************************
    localparam int          NUM_WORDS = 64;
    localparam logic [15:0] WIN_LO    = 16'h1000;
    localparam logic [15:0] WIN_HI    = 16'h10ff;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [15:0] OFS_CREV   = 16'h1000;
    localparam logic [15:0] OFS_ENDT   = 16'h1004;
    localparam logic [15:0] OFS_CUSW   = 16'h1008;
    localparam logic [15:0] OFS_DBIT   = 16'h100c;
    localparam logic [15:0] OFS_TEST   = 16'h1010;
    localparam logic [15:0] OFS_RWG    = 16'h1014;
    localparam logic [15:0] OFS_CCTL   = 16'h1018;
    localparam logic [15:0] OFS_NBIT   = 16'h101c;
    localparam logic [15:0] OFS_TSCF   = 16'h1020;
    localparam logic [15:0] OFS_TSVL   = 16'h1024;
    localparam logic [15:0] OFS_TOCF   = 16'h1028;
    localparam logic [15:0] OFS_TOVL   = 16'h102c;
    localparam logic [15:0] OFS_ECNT   = 16'h1040;
    localparam logic [15:0] OFS_PSTAT  = 16'h1044;
    localparam logic [15:0] OFS_TDCMP  = 16'h1048;
    localparam logic [15:0] OFS_IFLG   = 16'h1050;
    localparam logic [15:0] OFS_IENA   = 16'h1054;
    localparam logic [15:0] OFS_ILSEL  = 16'h1058;
    localparam logic [15:0] OFS_ILENA  = 16'h105c;
    localparam logic [15:0] OFS_GFLT   = 16'h1080;
    localparam logic [15:0] OFS_SFLT   = 16'h1084;
    localparam logic [15:0] OFS_XFLT   = 16'h1088;
    localparam logic [15:0] OFS_XMSK   = 16'h1090;
    localparam logic [15:0] OFS_HPRI   = 16'h1094;
    localparam logic [15:0] OFS_NDLO   = 16'h1098;
    localparam logic [15:0] OFS_NDHI   = 16'h109c;
    localparam logic [15:0] OFS_RF0CFG = 16'h10a0;
    localparam logic [15:0] OFS_RF0ST  = 16'h10a4;
    localparam logic [15:0] OFS_RF0ACK = 16'h10a8;
    localparam logic [15:0] OFS_RBCFG  = 16'h10ac;
    localparam logic [15:0] OFS_RF1CFG = 16'h10b0;
    localparam logic [15:0] OFS_RF1ST  = 16'h10b4;
    localparam logic [15:0] OFS_RF1ACK = 16'h10b8;
    localparam logic [15:0] OFS_RESZ   = 16'h10bc;
    localparam logic [15:0] OFS_TBCFG  = 16'h10c0;
    localparam logic [15:0] OFS_TFQST  = 16'h10c4;
    localparam logic [15:0] OFS_TESZ   = 16'h10c8;
    localparam logic [15:0] OFS_TRPEND = 16'h10cc;
    localparam logic [15:0] OFS_TADD   = 16'h10d0;
    localparam logic [15:0] OFS_TCAN   = 16'h10d4;
    localparam logic [15:0] OFS_TXOCC  = 16'h10d8;
    localparam logic [15:0] OFS_TCFIN  = 16'h10dc;
    localparam logic [15:0] OFS_TDIE   = 16'h10e0;
    localparam logic [15:0] OFS_TCIE   = 16'h10e4;
    localparam logic [15:0] OFS_TEFCFG = 16'h10f0;
    localparam logic [15:0] OFS_TEFST  = 16'h10f4;
    localparam logic [15:0] OFS_TEFACK = 16'h10f8;

    // ****************************************************************
    // Reset values and field layouts
    // ****************************************************************
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [31:0] RST_ENDT   = 32'h8765_4321;
    localparam logic [31:0] RST_DBIT   = 32'h0000_0a33;
    localparam logic [31:0] RST_CCTL   = 32'h0000_0019;
    localparam logic [31:0] RST_NBIT   = 32'h0600_0a03;
    localparam logic [31:0] RST_TOCF   = 32'hffff_0000;
    localparam logic [31:0] RST_XMSK   = 32'h1fff_ffff;
    localparam logic [31:0] MSK_FULL   = 32'hffff_ffff;
    localparam logic [31:0] MSK_ALIGN  = 32'hffff_fffc;
    localparam logic [31:0] MSK_XMSK   = 32'h1fff_ffff;
    localparam logic [31:0] MSK_CCTL_A = 32'h0000_0001;
    localparam logic [31:0] MSK_CCTL_I = 32'h0000_00fe;
    localparam logic [31:0] MSK_CCTL_P = 32'h0000_f300;
    localparam int          CCTL_INIT  = 0;
    localparam int          CCTL_CHG   = 1;

    // ****************************************************************
    // Access classes
    // ****************************************************************
    localparam logic [2:0] K_RSVD  = 3'h0;
    localparam logic [2:0] K_RO    = 3'h1;
    localparam logic [2:0] K_RW    = 3'h2;
    localparam logic [2:0] K_RP    = 3'h3;
    localparam logic [2:0] K_WC    = 3'h4;
    localparam logic [2:0] K_CTRL  = 3'h5;
    localparam logic [2:0] K_FLAG  = 3'h6;

    function automatic logic [2:0] kind_of(input logic [15:0] ofs);
        case (ofs)
            OFS_CREV, OFS_ENDT, OFS_CUSW, OFS_ECNT, OFS_PSTAT, OFS_HPRI,
            OFS_RF0ST, OFS_RF1ST, OFS_TFQST, OFS_TRPEND, OFS_TXOCC,
            OFS_TCFIN, OFS_TEFST:                       kind_of = K_RO;
            OFS_DBIT, OFS_TEST, OFS_RWG, OFS_NBIT, OFS_TSCF, OFS_TOCF,
            OFS_TDCMP, OFS_GFLT, OFS_SFLT, OFS_XFLT, OFS_XMSK,
            OFS_RF0CFG, OFS_RBCFG, OFS_RF1CFG, OFS_RESZ, OFS_TBCFG,
            OFS_TESZ, OFS_TEFCFG:                       kind_of = K_RP;
            OFS_IENA, OFS_ILSEL, OFS_ILENA, OFS_NDLO, OFS_NDHI,
            OFS_RF0ACK, OFS_RF1ACK, OFS_TADD, OFS_TCAN, OFS_TDIE,
            OFS_TCIE, OFS_TEFACK:                       kind_of = K_RW;
            OFS_TSVL, OFS_TOVL:                         kind_of = K_WC;
            OFS_CCTL:                                   kind_of = K_CTRL;
            OFS_IFLG:                                   kind_of = K_FLAG;
            default:                                    kind_of = K_RSVD;
        endcase
    endfunction

    function automatic logic [31:0] reset_of(input logic [15:0] ofs);
        case (ofs)
            OFS_DBIT: reset_of = RST_DBIT;
            OFS_NBIT: reset_of = RST_NBIT;
            OFS_TOCF: reset_of = RST_TOCF;
            OFS_XMSK: reset_of = RST_XMSK;
            default:  reset_of = RST_ZERO;
        endcase
    endfunction

    function automatic logic [31:0] wmask_of(input logic [15:0] ofs);
        case (ofs)
            OFS_SFLT, OFS_XFLT, OFS_RF0CFG, OFS_RF1CFG, OFS_TBCFG,
            OFS_TEFCFG: wmask_of = MSK_ALIGN;
            OFS_XMSK:   wmask_of = MSK_XMSK;
            default:    wmask_of = MSK_FULL;
        endcase
    endfunction

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } cfr_req_t;

    typedef struct packed {
        logic [31:0] ecnt;
        logic [31:0] pstat;
        logic [31:0] hpri;
        logic [31:0] rf0st;
        logic [31:0] rf1st;
        logic [31:0] tfqst;
        logic [31:0] trpend;
        logic [31:0] txocc;
        logic [31:0] tcfin;
        logic [31:0] tefst;
        logic [31:0] tsvl;
        logic [31:0] tovl;
    } cfr_stat_t;

    typedef logic [NUM_WORDS-1:0][31:0] cfr_words_t;

endpackage

// [core/cfr_reg.sv]
// One stored 32-bit register word with write mask.
// Assumes the caller already qualified the write enable.
`timescale 1ns/1ps
module cfr_reg #(
    parameter logic [31:0] RESET = 32'h0000_0000,
    parameter logic [31:0] WMASK = 32'hffff_ffff
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wr_en_in,
    input  wire logic [31:0] wdata_in,
    output logic      [31:0] q_out
);
    logic [31:0] q_q;
    logic [31:0] q_d;

    // ****************************************************************
    // Next value: masked bits always store zero
    // ****************************************************************
    always_comb begin
        q_d = q_q;
        if (wr_en_in) begin
            q_d = wdata_in & WMASK;
        end
    end

    // Register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q_q <= RESET;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_out = q_q;
endmodule

// [tb/cfr_host_model.sv]
// Host side of the register port: issues word reads and writes.
// Assumes the bank samples requests on the rising edge of clk.
`timescale 1ns/1ps
module cfr_host_model (
    input  wire logic             clk,
    input  wire logic             rvalid,
    input  wire logic [31:0]      rdata,
    output cfr_pkg::cfr_req_t     req
);
    import cfr_pkg::*;

    // Idle bus until the bench asks for a transfer
    initial req = '0;

    // Message RAM offsets go in without the upper prefix
    function automatic logic [31:0] ram_ofs(input logic [31:0] full);
        return {16'h0000, full[15:0]};
    endfunction

    // Write strobe held across one rising edge, launched on a falling edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask

    // Answer is taken half a cycle after the edge that follows the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge clk);
        d = rdata;
        v = rvalid;
        req = '0;
    endtask
endmodule

// [tb/cfr_regbank_asserts.sv]
// Port-level checks of the register bank.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module cfr_regbank_asserts (
    input wire logic                 MCLK_IN,
    input wire logic                 NRST_IN,
    input wire cfr_pkg::cfr_req_t    HOST_REQ_IN,
    input wire cfr_pkg::cfr_stat_t   CORE_STAT_IN,
    input wire logic [31:0]          IRQ_EVENT_IN,
    input wire logic [31:0]          RDATA_OUT,
    input wire logic                 RVALID_OUT,
    input wire cfr_pkg::cfr_words_t  CFG_OUT,
    input wire logic                 TSVL_CLR_OUT,
    input wire logic                 TOVL_CLR_OUT,
    input wire logic                 RSVD_HIT_OUT,
    input wire logic                 PROT_BLOCK_OUT
);
    import cfr_pkg::*;

    // ****************************************************************
    // Request decode helpers
    // ****************************************************************
    wire logic        wr     = HOST_REQ_IN.wr;
    wire logic        rd     = HOST_REQ_IN.rd;
    wire logic [15:0] a      = HOST_REQ_IN.addr;
    wire logic        open_w = CFG_OUT[6][1:0] == 2'b11;
    wire logic        out_w  = a < WIN_LO || a > WIN_HI;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    // ****************************************************************
    // Properties
    // ****************************************************************
    chk_read_answer: assert property (rd |=> RVALID_OUT)
        else $error("read strobe got no answer");
    chk_rvalid_single: assert property (!rd |=> !RVALID_OUT)
        else $error("answer without a read");
    chk_outside_hit: assert property ((rd || wr) && out_w |=> RSVD_HIT_OUT && RDATA_OUT == 32'h0)
        else $error("access outside window not flagged");
    chk_rsvd_zero: assert property (rd && !out_w
        && a[7:2] inside {12, 13, 14, 15, 19, [24:31], 35, 58, 59, 63} |=> RDATA_OUT == 32'h0 && RSVD_HIT_OUT)
        else $error("reserved word read not zero");
    chk_start_align: assert property (wr && a == OFS_SFLT && open_w
        |=> CFG_OUT[33] == {$past(HOST_REQ_IN.wdata[31:2]), 2'b00})
        else $error("start address low bits kept");
    chk_prot_blocked: assert property (wr && a == OFS_DBIT && !open_w
        |=> PROT_BLOCK_OUT && $stable(CFG_OUT[3]))
        else $error("locked timing word changed");
    chk_prot_taken: assert property (wr && a == OFS_NBIT && open_w
        |=> CFG_OUT[7] == $past(HOST_REQ_IN.wdata) && !PROT_BLOCK_OUT)
        else $error("open timing write lost");
    chk_mask_width: assert property (wr && a == OFS_XMSK && open_w
        |=> CFG_OUT[36] == ($past(HOST_REQ_IN.wdata) & 32'h1fff_ffff))
        else $error("id mask width wrong");
    chk_ack_store: assert property (wr && a == OFS_RF0ACK |=> CFG_OUT[42] == $past(HOST_REQ_IN.wdata))
        else $error("fifo ack not stored");
    chk_pend_ro: assert property (rd && a == OFS_TRPEND
        |=> RDATA_OUT == $past(CORE_STAT_IN.trpend) && CFG_OUT[51] == 32'h0)
        else $error("pending word not read only");
endmodule

bind cfr_regbank cfr_regbank_asserts u_chk (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
    .HOST_REQ_IN(HOST_REQ_IN), .CORE_STAT_IN(CORE_STAT_IN), .IRQ_EVENT_IN(IRQ_EVENT_IN),
    .RDATA_OUT(RDATA_OUT), .RVALID_OUT(RVALID_OUT), .CFG_OUT(CFG_OUT), .TSVL_CLR_OUT(TSVL_CLR_OUT),
    .TOVL_CLR_OUT(TOVL_CLR_OUT), .RSVD_HIT_OUT(RSVD_HIT_OUT), .PROT_BLOCK_OUT(PROT_BLOCK_OUT));

// [tb/can_fd_controller_register_map_tb.sv]
// Self-checking bench of the register bank against a word model.
// Assumes cfr_host_model as bus driver and the bound port checker.
`timescale 1ns/1ps
module can_fd_controller_register_map_tb;
    import cfr_pkg::*;

    logic        MCLK_IN;
    logic        NRST_IN;
    cfr_req_t    req;
    cfr_stat_t   st;
    logic [31:0] irq, rdata, mdl[64];
    logic        rvalid, tsc, toc, rhit, pblk;
    cfr_words_t  cfg;
    int          seed = 98719;
    int          bad_count, tests_run, cycles;

    // Free-running 200 MHz clock
    initial begin
        MCLK_IN = 1'b0;
        forever #2.5 MCLK_IN = ~MCLK_IN;
    end

    cfr_regbank uut (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .HOST_REQ_IN(req), .CORE_STAT_IN(st),
        .IRQ_EVENT_IN(irq), .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .CFG_OUT(cfg),
        .TSVL_CLR_OUT(tsc), .TOVL_CLR_OUT(toc), .RSVD_HIT_OUT(rhit), .PROT_BLOCK_OUT(pblk));
    cfr_host_model host (.clk(MCLK_IN), .rvalid(rvalid), .rdata(rdata), .req(req));

    // ****************************************************************
    // Word model
    // ****************************************************************
    function automatic bit isprot(input int i);
        return i inside {3, 4, 5, 7, 8, 10, 18, 32, 33, 34, 36, 40, 43, 44, 47, 48, 50, 60};
    endfunction

    task automatic mreset();
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[3]  = 32'h0000_0a33;
        mdl[6]  = 32'h0000_0019;
        mdl[7]  = 32'h0600_0a03;
        mdl[10] = 32'hffff_0000;
        mdl[36] = 32'h1fff_ffff;
    endtask

    // Control state seen before the write decides protection
    function automatic void mwr(input logic [15:0] a, input logic [31:0] d);
        int          i;
        logic [31:0] c;
        i = a[7:2];
        c = mdl[6];
        if (a < 16'h1000 || a > 16'h10ff) return;
        if (isprot(i)) begin
            if (c[1:0] == 2'b11) mdl[i] = d & (i inside {33, 34, 40, 44, 48, 60} ? 32'hffff_fffc :
                i == 36 ? 32'h1fff_ffff : 32'hffff_ffff);
        end else if (i inside {21, 22, 23, 38, 39, 42, 46, 52, 53, 56, 57, 62}) begin
            mdl[i] = d;
        end else if (i == 20) begin
            mdl[20] = mdl[20] & ~d;
        end else if (i == 6) begin
            mdl[6][0] = d[0];
            if (c[0]) mdl[6][7:1] = d[7:1];
            if (c[1:0] == 2'b11) {mdl[6][15:12], mdl[6][9:8]} = {d[15:12], d[9:8]};
        end
    endfunction

    // Status words come from the core, word 1 is a fixed constant, reserved and other unstored words stay zero
    function automatic logic [31:0] mrd(input int a);
        if (a < 32'h1000 || a > 32'h10ff) return 32'h0;
        case (a[7:2])
            1: return 32'h8765_4321;
            9: return st.tsvl;
            11: return st.tovl;
            16: return st.ecnt;
            17: return st.pstat;
            37: return st.hpri;
            41: return st.rf0st;
            45: return st.rf1st;
            49: return st.tfqst;
            51: return st.trpend;
            54: return st.txocc;
            55: return st.tcfin;
            61: return st.tefst;
            default: return mdl[a[7:2]];
        endcase
    endfunction

    // ****************************************************************
    // Checking and sequences
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_all(input string nm);
        for (int i = 0; i < 64; i++) chk("stored word", mdl[i], cfg[i]);
        $display("test %s done", nm);
    endtask

    // Random word into every address but the control word
    task automatic wr_all(input string nm);
        logic [31:0] d;
        logic        lk;
        for (int i = 0; i < 64; i++) begin
            if (i == 6) continue;
            d = $random(seed);
            if (i inside {33, 34, 40, 44, 48, 60}) d = host.ram_ofs(d);
            lk = mdl[6][1:0] != 2'b11;
            host.wr(16'h1000 + 16'(i * 4), d);
            chk("block pulse", {31'h0, isprot(i) && lk}, {31'h0, pblk});
            chk("clear pulses", {30'h0, i == 11, i == 9}, {30'h0, toc, tsc});
            mwr(16'h1000 + 16'(i * 4), d);
            chk("written word", mdl[i], cfg[i]);
        end
        cmp_all(nm);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge MCLK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        logic [31:0] d, ev;
        logic        v;
        NRST_IN = 1'b0;
        irq = 32'h0;
        st = '0;
        mreset();
        repeat (20) @(negedge MCLK_IN);
        NRST_IN = 1'b1;
        cmp_all("reset values");
        wr_all("locked writes");
        host.wr(16'h1018, 32'h0000_0003);
        mwr(16'h1018, 32'h0000_0003);
        wr_all("open writes");
        for (int i = 0; i < 12; i++) st[i * 32 +: 32] = $random(seed);
        for (int a = 32'h0ff8; a <= 32'h1104; a += 4) begin
            host.rd(16'(a), d, v);
            chk("read valid", 32'h1, {31'h0, v});
            chk("read data", mrd(a), d);
        end
        $display("test read sweep done");
        ev = $random(seed);
        @(negedge MCLK_IN) irq = ev;
        @(negedge MCLK_IN) irq = 32'h0;
        mdl[20] = mdl[20] | ev;
        chk("flags set", mdl[20], cfg[20]);
        fork
            host.wr(16'h1050, ev);
            @(negedge MCLK_IN) irq = ev & 32'hff;
        join
        irq = 32'h0;
        mwr(16'h1050, ev);
        mdl[20] = mdl[20] | (ev & 32'hff);
        cmp_all("flag clear");
        NRST_IN = 1'b0;
        repeat (3) @(negedge MCLK_IN);
        NRST_IN = 1'b1;
        mreset();
        cmp_all("second reset");
        report_and_stop();
    end
endmodule
